// *** shared/eiu_pkg.sv ***
// Package of constants and types for the external interrupt unit.
package eiu_pkg;
  // ==========================================================
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] PCHG_IDX = 8'h15;
  localparam logic [7:0] CTRL_IDX = 8'h35;
  localparam logic [7:0] FLAGS_IDX = 8'h3A;
  localparam logic [7:0] ENAB_IDX = 8'h3B;
  localparam logic [7:0] STAT_IDX = 8'h40;
  localparam logic [7:0] ICLR_IDX = 8'h41;
  localparam logic [7:0] IEN_IDX = 8'h42;
  localparam logic [7:0] ACK_IDX = 8'h43;
  localparam logic [7:0] VEC_IDX = 8'h44;
  localparam logic [9:0] PCHG_ADDR = {PCHG_IDX, 2'b00};
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] FLAGS_ADDR = {FLAGS_IDX, 2'b00};
  localparam logic [9:0] ENAB_ADDR = {ENAB_IDX, 2'b00};
  localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [9:0] ICLR_ADDR = {ICLR_IDX, 2'b00};
  localparam logic [9:0] IEN_ADDR = {IEN_IDX, 2'b00};
  localparam logic [9:0] ACK_ADDR = {ACK_IDX, 2'b00};
  localparam logic [9:0] VEC_ADDR = {VEC_IDX, 2'b00};
  // ==========================================================
  // Field positions, masks and reset values.
  localparam int EXT_BIT = 6;
  localparam int PC_BIT = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h7B;
  localparam logic [7:0] FLAG_MASK = 8'h60;
  localparam logic [7:0] PCHG_MASK = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_PC = 6;
  // ==========================================================
  // Sense modes and vector table.
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } eiu_sense_e;
  localparam int NUM_VEC = 15;
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_EXT = 4'h1;
  localparam logic [3:0] VEC_PC = 4'h2;
  localparam logic [3:0] VEC_T1CA = 4'h3;
  localparam logic [3:0] VEC_T1OV = 4'h4;
  localparam logic [3:0] VEC_T0OV = 4'h5;
  localparam logic [3:0] VEC_EERDY = 4'h6;
  localparam logic [3:0] VEC_CMP = 4'h7;
  localparam logic [3:0] VEC_ADCC = 4'h8;
  localparam logic [3:0] VEC_T1CB = 4'h9;
  localparam logic [3:0] VEC_T0CA = 4'hA;
  localparam logic [3:0] VEC_T0CB = 4'hB;
  localparam logic [3:0] VEC_WDOG = 4'hC;
  localparam logic [3:0] VEC_SSTART = 4'hD;
  localparam logic [3:0] VEC_SOVF = 4'hE;
  localparam int NUM_PERIPH = 12;
  // ==========================================================
  // Request to the core.
  typedef struct packed {
    logic valid;
    logic [3:0] vector;
    logic [15:0] address;
  } eiu_req_s;
endpackage

// *** hdl/eiu_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module eiu_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // ==========================================================
  // Stages.
  // The pins idle high, so the chain resets high to avoid a false edge.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = level_q;
endmodule // eiu_sync

// *** hdl/eiu_top.sv ***
// External interrupt unit: pin sensing, flags, vectors and AXI4-Lite.
`timescale 1ns/1ps
module eiu_top
  import eiu_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic io_clk_run,
  input wire logic global_irq_en,
  input wire logic core_reset_req,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic ext_irq_pin,
  input wire logic [NUM_PC-1:0] pin_change_inputs,
  input wire logic vector_ack,
  output eiu_req_s irq_req,
  output logic wake_req,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] pchg_mask_q;
  logic [7:0] ctrl_q;
  logic [7:0] enab_q;
  logic ext_flag_q;
  logic pc_flag_q;
  logic [1:0] stat_q;
  logic [1:0] ien_q;
  logic ext_prev_q;
  logic [NUM_PC-1:0] pc_prev_q;
  logic ext_lvl;
  logic [NUM_PC-1:0] pc_lvl;
  logic [1:0] sense;
  logic ext_edge;
  logic pc_hit;
  logic ext_level_req;
  logic ext_take;
  logic pc_take;
  logic [NUM_VEC-1:0] pend;
  logic [3:0] vec_d;
  logic found;
  eiu_req_s req_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic rd_hit;
  logic ack_ext;
  logic ack_pc;

  // ==========================================================
  // Pin sampling.
  eiu_sync #(.W(NUM_PC + 1)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin({pin_change_inputs, ext_irq_pin}),
    .level({pc_lvl, ext_lvl})
  );

  assign sense = ctrl_q[1:0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_q <= 1'b1;
      pc_prev_q <= '1;
    end else begin
      // External-pin edges are judged only while the I/O clock runs, and its last level holds; pin changes are always judged.
      if (io_clk_run) begin
        ext_prev_q <= ext_lvl;
      end
      pc_prev_q <= pc_lvl;
    end
  end

  // Pins are read regardless of their direction, so software can self-trigger.
  always_comb begin
    ext_edge = 1'b0;
    if (io_clk_run) begin
      case (sense)
        SENSE_ANY: ext_edge = ext_lvl ^ ext_prev_q;
        SENSE_FALL: ext_edge = ext_prev_q & ~ext_lvl;
        SENSE_RISE: ext_edge = ~ext_prev_q & ext_lvl;
        default: ext_edge = 1'b0;
      endcase
    end
  end

  assign pc_hit = |((pc_lvl ^ pc_prev_q) & pchg_mask_q[NUM_PC-1:0]);
  // Level requests follow the pin directly, so a vanished low gives none.
  assign ext_level_req = (sense == SENSE_LOW) & ~ext_lvl;
  // The raw low level wakes the device without any clock.
  assign wake_req = enab_q[EXT_BIT] & (sense == SENSE_LOW) & ~ext_irq_pin
    | (enab_q[PC_BIT] & pc_hit);

  // ==========================================================
  // Flags. Set wins over every clear.
  assign ack_ext = vector_ack & req_q.valid & (req_q.vector == VEC_EXT);
  assign ack_pc = vector_ack & req_q.valid & (req_q.vector == VEC_PC);
  assign wr_hit = wr_go & wstrb_q[0];
  assign wbyte = wdata_q[7:0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_flag_q <= 1'b0;
    end else if (sense == SENSE_LOW) begin
      ext_flag_q <= 1'b0;
    end else if (ext_edge) begin
      ext_flag_q <= 1'b1;
    end else if (ack_ext ||
        (wr_hit && awaddr_q == FLAGS_ADDR && wbyte[EXT_BIT])) begin
      ext_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_flag_q <= 1'b0;
    end else if (pc_hit) begin
      pc_flag_q <= 1'b1;
    end else if (ack_pc ||
        (wr_hit && awaddr_q == FLAGS_ADDR && wbyte[PC_BIT])) begin
      pc_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Vector selection.
  assign ext_take = global_irq_en & enab_q[EXT_BIT]
    & (ext_flag_q | ext_level_req);
  assign pc_take = global_irq_en & enab_q[PC_BIT] & pc_flag_q;
  assign pend = {periph_req & {NUM_PERIPH{global_irq_en}},
    pc_take, ext_take, core_reset_req};

  always_comb begin
    vec_d = VEC_RESET;
    found = 1'b0;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (pend[i] && !found) begin
        vec_d = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= '0;
    end else begin
      // Valid drops for one cycle after a take, so a flag cleared by the take is not taken twice.
      req_q.valid <= found & ~vector_ack;
      req_q.vector <= vec_d;
      req_q.address <= {12'h000, vec_d};
    end
  end

  assign irq_req = req_q;

  // ==========================================================
  // Summary interrupt: sticky status, write-one clear, enable.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? ext_edge | ext_level_req : pc_hit) begin
          stat_q[i] <= 1'b1;
        end else if (wr_hit && awaddr_q == ICLR_ADDR && wbyte[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(stat_q & ien_q);

  // ==========================================================
  // AXI4-Lite write path.
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign wr_go = aw_full_q & w_full_q & ~bvalid_q;

  // Address and data are latched apart, so either channel may come first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == PCHG_ADDR || awaddr_q == CTRL_ADDR ||
        awaddr_q == FLAGS_ADDR || awaddr_q == ENAB_ADDR ||
        awaddr_q == ICLR_ADDR || awaddr_q == IEN_ADDR) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Control registers; reserved bits are never stored, so they read as zero.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pchg_mask_q <= REG_RESET;
    end else if (wr_hit && awaddr_q == PCHG_ADDR) begin
      pchg_mask_q <= wbyte & PCHG_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= REG_RESET;
    end else if (wr_hit && awaddr_q == CTRL_ADDR) begin
      ctrl_q <= wbyte & CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enab_q <= REG_RESET;
    end else if (wr_hit && awaddr_q == ENAB_ADDR) begin
      enab_q <= wbyte & FLAG_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ien_q <= 2'b00;
    end else if (wr_hit && awaddr_q == IEN_ADDR) begin
      ien_q <= wbyte[1:0];
    end
  end

  // ==========================================================
  // AXI4-Lite read path.
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      PCHG_ADDR: rd_val = pchg_mask_q;
      CTRL_ADDR: rd_val = ctrl_q;
      FLAGS_ADDR: rd_val = {1'b0, ext_flag_q, pc_flag_q, 5'h00};
      ENAB_ADDR: rd_val = enab_q;
      STAT_ADDR: rd_val = {6'h00, stat_q};
      ICLR_ADDR: rd_val = 8'h00;
      IEN_ADDR: rd_val = {6'h00, ien_q};
      VEC_ADDR: rd_val = {req_q.valid, 3'h0, req_q.vector};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_val};
      rresp_q <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule // eiu_top

// *** tb/eiu_monitor.sv ***
// Port checker of the external interrupt unit, bound to its top module.
`timescale 1ns/1ps
module eiu_monitor
  import eiu_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic global_irq_en,
  input wire logic core_reset_req,
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic vector_ack,
  input wire eiu_req_s irq_req,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Vector dispatch.
  vec_addr_a: assert property (
    irq_req.valid |-> irq_req.address == {12'h000, irq_req.vector})
    else $error("vector address wrong");
  reset_first_a: assert property (
    core_reset_req && !vector_ack |=>
    irq_req.valid && irq_req.vector == VEC_RESET)
    else $error("reset vector not first");
  periph_low_a: assert property (
    global_irq_en && periph_req[0] && !core_reset_req && !vector_ack |=>
    irq_req.valid && irq_req.vector <= VEC_T1CA)
    else $error("timer vector lost");
  global_gate_a: assert property (
    !global_irq_en && !core_reset_req |=> !irq_req.valid)
    else $error("request without global flag");
  // ==========================================================
  // Register bus.
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer not held");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  cover property (irq_req.valid && irq_req.vector == VEC_EXT);
  cover property (irq_req.valid && irq_req.vector == VEC_PC);
  cover property (irq_req.valid && irq_req.vector == VEC_RESET);
endmodule // eiu_monitor

bind eiu_top eiu_monitor u_mon (
  .core_clk, .reset_n, .global_irq_en, .core_reset_req, .periph_req,
  .vector_ack, .irq_req, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready
);

// *** tb/eiu_partner.sv ***
// Model of the interrupt pins and of the core's vector dispatch.
`timescale 1ns/1ps
module eiu_partner
  import eiu_pkg::*;
(
  input wire logic core_clk,
  input wire eiu_req_s irq_req,
  output logic ext_irq_pin,
  output logic [NUM_PC-1:0] pin_change_inputs,
  output logic vector_ack
);
  bit ack_on = 1'b0;
  int n_taken = 0;
  logic [3:0] last_vec = 4'h0;
  // ==========================================================
  // Pins idle high on their pull-ups.
  initial begin
    ext_irq_pin = 1'b1;
    pin_change_inputs = 6'h3F;
    vector_ack = 1'b0;
  end
  // The core only takes requests when allowed, so flags can be read first.
  always @(posedge core_clk) begin
    vector_ack <= 1'b0;
    if (ack_on && irq_req.valid && !vector_ack) begin
      vector_ack <= 1'b1;
      last_vec <= irq_req.vector;
      n_taken <= n_taken + 1;
    end
  end
  // Every level is held eight clocks, far beyond one clock period.
  task automatic ext(input logic v);
    ext_irq_pin <= v;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pc(input int i);
    pin_change_inputs <= pin_change_inputs ^ (6'h01 << i);
    repeat (8) @(posedge core_clk);
  endtask
endmodule // eiu_partner

// *** tb/test_external_interrupt_unit.sv ***
// Self-checking bench of the external interrupt unit.
`timescale 1ns/1ps
module test_external_interrupt_unit
  import eiu_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n;
  logic io_clk_run;
  logic global_irq_en;
  logic core_reset_req;
  logic [NUM_PERIPH-1:0] periph_req;
  logic ext_irq_pin, vector_ack, wake_req, irq;
  logic [NUM_PC-1:0] pin_change_inputs;
  eiu_req_s irq_req;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_fail = 0;
  int tests_run = 0;
  int k;
  logic [9:0] ra [4] = '{PCHG_ADDR, CTRL_ADDR, FLAGS_ADDR, ENAB_ADDR};
  logic [7:0] rm [4] = '{8'h3F, 8'h7B, 8'h00, 8'h60};
  logic [7:0] fe [4] = '{8'h00, 8'h40, 8'h40, 8'h00};
  logic [7:0] re [4] = '{8'h00, 8'h40, 8'h00, 8'h40};

  always #2.5 core_clk = ~core_clk;

  eiu_top dut (
    .core_clk, .reset_n, .io_clk_run, .global_irq_en, .core_reset_req,
    .periph_req, .ext_irq_pin, .pin_change_inputs, .vector_ack, .irq_req,
    .wake_req, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  eiu_partner pm (
    .core_clk, .irq_req, .ext_irq_pin, .pin_change_inputs, .vector_ack
  );
  // ==========================================================
  // Bus and check helpers.
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bound(input int i);
    if (i >= 40) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Handshakes are judged before the edge so no process race decides them.
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic ta, tw, dn;
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      dn = s_axi_bvalid;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (dn) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
    bound(i);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ta, dn;
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      dn = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (dn) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    bound(i);
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask
  // Lets the core take exactly one request and checks its vector.
  task automatic take(input logic [3:0] e);
    int i, b;
    repeat (4) @(posedge core_clk);
    b = pm.n_taken;
    pm.ack_on <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (pm.n_taken != b) break;
    end
    @(posedge core_clk);
    pm.ack_on <= 1'b0;
    bound(i);
    chk({28'h0, pm.last_vec}, {28'h0, e});
  endtask
  // ==========================================================
  // Test sequence.
  initial begin
    reset_n <= 1'b0;
    io_clk_run <= 1'b1;
    global_irq_en <= 1'b0;
    core_reset_req <= 1'b0;
    periph_req <= 12'h000;
    s_axi_awaddr <= 10'h000;
    s_axi_araddr <= 10'h000;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (k = 0; k < 4; k++) begin
      rchk(ra[k], 32'h0);
      wr(ra[k], 8'hFF);
      rchk(ra[k], {24'h000000, rm[k]});
    end
    s_axi_wstrb <= 4'hE;
    wr(PCHG_ADDR, 8'h00);
    rchk(PCHG_ADDR, 32'h3F);
    s_axi_wstrb <= 4'hF;
    rd(10'h3FC, d, r);
    chk({30'h0, r}, 32'h2);
    $display("registers done");
    for (k = 0; k < 4; k++) begin
      wr(CTRL_ADDR, 8'(k));
      wr(FLAGS_ADDR, 8'h60);
      pm.ext(1'b0);
      chk({31'h0, wake_req}, {31'h0, k == 0});
      rchk(FLAGS_ADDR, {24'h000000, fe[k]});
      wr(FLAGS_ADDR, 8'h60);
      pm.ext(1'b1);
      rchk(FLAGS_ADDR, {24'h000000, re[k]});
    end
    io_clk_run <= 1'b0;
    wr(FLAGS_ADDR, 8'h60);
    wr(CTRL_ADDR, 8'h02);
    pm.ext(1'b0);
    rchk(FLAGS_ADDR, 32'h0);
    pm.ext(1'b1);
    io_clk_run <= 1'b1;
    $display("sense modes done");
    wr(PCHG_ADDR, 8'h04);
    wr(FLAGS_ADDR, 8'h60);
    pm.pc(0);
    rchk(FLAGS_ADDR, 32'h0);
    pm.pc(2);
    pm.ext(1'b0);
    rchk(FLAGS_ADDR, 32'h60);
    core_reset_req <= 1'b1;
    global_irq_en <= 1'b1;
    take(VEC_RESET);
    core_reset_req <= 1'b0;
    take(VEC_EXT);
    take(VEC_PC);
    rchk(FLAGS_ADDR, 32'h0);
    periph_req <= 12'h001;
    take(VEC_T1CA);
    periph_req <= 12'h800;
    take(VEC_SOVF);
    periph_req <= 12'h000;
    pm.ext(1'b1);
    wr(CTRL_ADDR, 8'h00);
    pm.ext(1'b0);
    rchk(VEC_ADDR, 32'h81);
    chk({16'h0000, irq_req.address}, 32'h1);
    take(VEC_EXT);
    take(VEC_EXT);
    pm.ext(1'b1);
    global_irq_en <= 1'b0;
    $display("dispatch done");
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rchk(PCHG_ADDR, 32'h0);
    rchk(ENAB_ADDR, 32'h0);
    rchk(FLAGS_ADDR, 32'h0);
    $display("second reset done");
    wr(CTRL_ADDR, 8'h02);
    wr(ICLR_ADDR, 8'h03);
    wr(IEN_ADDR, 8'h01);
    chk({31'h0, irq}, 32'h0);
    pm.ext(1'b0);
    chk({31'h0, irq}, 32'h1);
    rchk(STAT_ADDR, 32'h1);
    wr(IEN_ADDR, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wr(ICLR_ADDR, 8'h01);
    rchk(STAT_ADDR, 32'h0);
    $display("interrupt line done");
    report_and_stop();
  end
endmodule // test_external_interrupt_unit
